//--- mic_irq_ctrl.sv
`timescale 1ns/100ps
module mic_irq_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin_n,
	input wire logic [mic_pkg::MIC_NEV-1:0] event_in,
	input wire logic instr_end,
	input wire logic ldi_opt_clr,
	input wire logic return_from_interrupt,
	input wire logic low_power,
	input wire logic [11:0] pc_in,
	input wire mic_pkg::mic_flags_s flags_in,
	output mic_pkg::mic_grant_s grant_q,
	output logic [11:0] stack0_q,
	output mic_pkg::mic_flags_s flags_q,
	output mic_pkg::mic_mode_e mode_q,
	output logic wake_q
);
	import mic_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] nmi_sync_q;
	logic [MIC_NEV-1:0] ev_s1_q, ev_s2_q, ev_prev_q;
	logic nmi_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_sync_q <= 2'b11;
			nmi_prev_q <= 1'b1;
			ev_s1_q <= '0;
			ev_s2_q <= '0;
			ev_prev_q <= '0;
		end else if (clk_en) begin
			nmi_sync_q <= {nmi_sync_q[0], nmi_pin_n};
			nmi_prev_q <= nmi_sync_q[1];
			ev_s1_q <= event_in;
			ev_s2_q <= ev_s1_q;
			ev_prev_q <= ev_s2_q;
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic [7:0] option_q;
	logic [MIC_NEV-1:0] evmask_q, evflag_q;
	logic stack_valid_q, inhibit_q, nmi_latch_q;
	logic [1:0] ldi_cnt_q;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire hit_opt = paddr == MIC_OPTION_OFF;
	wire hit_msk = paddr == MIC_EVMASK_OFF;
	wire hit_flg = paddr == MIC_EVFLAG_OFF;
	wire hit_sta = paddr == MIC_STATUS_OFF;
	wire mapped = hit_opt || hit_msk || hit_flg || hit_sta;
	// Option register is write-only: reads return zero
	wire [31:0] rd_mux = hit_msk ? {22'h0, evmask_q} :
		hit_flg ? {22'h0, evflag_q} :
		hit_sta ? {26'h0, mode_q, stack_valid_q, wake_q, inhibit_q, nmi_latch_q} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !pready;
			pslverr <= psel && !pready && !mapped;
			prdata <= (psel && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// Whole-byte writes only; unused bits forced to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_q <= MIC_OPTION_RST;
			evmask_q <= MIC_EVMASK_RST;
		end else if (clk_en && wr && pready) begin
			if (hit_opt)
				option_q <= pwdata[7:0] & MIC_OPTION_USED;
			if (hit_msk)
				evmask_q <= pwdata[MIC_NEV-1:0];
		end
	end

	wire global_irq_enable = option_q[MIC_GLB_EN_BIT];
	wire level_edge_select = option_q[MIC_LVL_SEL_BIT];
	wire edge_polarity_select = option_q[MIC_POL_SEL_BIT];

	// ---------------------------------------------------------------
	// Event flags and routing
	// ---------------------------------------------------------------
	// Peripheral events are high-active pulses; flags set wins over a write-one clear
	wire [MIC_NEV-1:0] ev_rise = ev_s2_q & ~ev_prev_q;
	wire flg_clr = wr && pready && hit_flg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			evflag_q <= '0;
		else if (clk_en)
			evflag_q <= (evflag_q & ~(flg_clr ? pwdata[MIC_NEV-1:0] : '0)) | ev_rise;
	end
	// Masked event levels OR onto their sources; active low like pins
	wire [MIC_NEV-1:0] ev_on = ev_s2_q & evmask_q;
	wire src1_n = !(ev_on[MIC_EV_SPI] || ev_on[MIC_EV_PA] || ev_on[MIC_EV_PE]);
	wire src2_n = !(ev_on[MIC_EV_PB] || ev_on[MIC_EV_PD]);
	wire src3_n = !ev_on[MIC_EV_ART];
	wire src4_n = !(ev_on[MIC_EV_TIMER] || ev_on[MIC_EV_CONV] ||
		ev_on[MIC_EV_SRX] || ev_on[MIC_EV_STX]);
	logic src1_prev_q, src2_prev_q;

	// ---------------------------------------------------------------
	// Edge latches
	// ---------------------------------------------------------------
	logic edge1_q, edge2_q;
	wire nmi_fall = nmi_prev_q && !nmi_sync_q[1];
	wire s1_fall = src1_prev_q && !src1_n;
	wire s2_edge = edge_polarity_select ? (!src2_prev_q && src2_n) :
		(src2_prev_q && !src2_n);

	// ---------------------------------------------------------------
	// Arbitration
	// ---------------------------------------------------------------
	wire req1 = level_edge_select ? !src1_n : edge1_q;
	wire mask_ok = global_irq_enable && !inhibit_q;
	wire take_nmi = nmi_latch_q && mode_q != MIC_MODE_NMI;
	wire take1 = mask_ok && req1;
	wire take2 = mask_ok && edge2_q;
	wire take3 = mask_ok && !src3_n;
	wire take4 = mask_ok && !src4_n;
	wire any_take = instr_end && (take_nmi || take1 || take2 || take3 || take4);
	wire [2:0] sel_src = take_nmi ? 3'h0 : take1 ? 3'h1 : take2 ? 3'h2 :
		take3 ? 3'h3 : 3'h4;
	wire [11:0] sel_vec = take_nmi ? MIC_VEC0 : take1 ? MIC_VEC1 : take2 ? MIC_VEC2 :
		take3 ? MIC_VEC3 : MIC_VEC4;
	// Option-clearing load still running within its first cycles
	wire ldi_window = ldi_opt_clr && ldi_cnt_q < 2'(MIC_LDI_MISS_CYC);
	wire no_swap = !take_nmi && mode_q == MIC_MODE_NORMAL && ldi_window;
	wire clr1 = any_take && sel_src == 3'h1;
	wire clr2 = any_take && sel_src == 3'h2;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src1_prev_q <= 1'b1;
			src2_prev_q <= 1'b1;
			edge1_q <= 1'b0;
			edge2_q <= 1'b0;
			nmi_latch_q <= 1'b0;
			ldi_cnt_q <= 2'h0;
		end else if (clk_en) begin
			src1_prev_q <= src1_n;
			src2_prev_q <= src2_n;
			ldi_cnt_q <= ldi_opt_clr ? ldi_cnt_q + ((ldi_cnt_q == 2'h3) ? 2'h0 : 2'h1) : 2'h0;
			// Set beats clear; only one request is held
			edge1_q <= (edge1_q && !clr1) || (!level_edge_select && s1_fall);
			edge2_q <= (edge2_q && !clr2) || s2_edge;
			nmi_latch_q <= (nmi_latch_q && !(any_take && take_nmi)) || nmi_fall;
		end
	end

	// ---------------------------------------------------------------
	// Entry and return sequence
	// ---------------------------------------------------------------
	mic_flags_s flags_norm_q, flags_irq_q, flags_nmi_q;
	mic_mode_e mode_prev_q;
	logic swapped_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grant_q <= '0;
			stack0_q <= 12'h000;
			stack_valid_q <= 1'b0;
			flags_q <= '0;
			flags_norm_q <= '0;
			flags_irq_q <= '0;
			flags_nmi_q <= '0;
			mode_q <= MIC_MODE_NORMAL;
			mode_prev_q <= MIC_MODE_NORMAL;
			inhibit_q <= 1'b0;
			swapped_q <= 1'b1;
			wake_q <= 1'b0;
		end else if (clk_en) begin
			// Wake needs global enable even for the non-maskable source
			wake_q <= low_power && global_irq_enable &&
				(nmi_latch_q || req1 || edge2_q || !src3_n || !src4_n);
			grant_q <= '0;
			if (any_take) begin
				grant_q <= '{
					take: 1'b1,
					src: sel_src,
					vector: sel_vec,
					swap_flags: !no_swap
				};
				stack0_q <= pc_in;
				stack_valid_q <= 1'b1;
				inhibit_q <= 1'b1;
				mode_prev_q <= mode_q;
				mode_q <= take_nmi ? MIC_MODE_NMI : MIC_MODE_IRQ;
				swapped_q <= !no_swap;
				case (mode_q)
					MIC_MODE_NORMAL: flags_norm_q <= flags_in;
					MIC_MODE_IRQ: flags_irq_q <= flags_in;
					default: flags_nmi_q <= flags_in;
				endcase
				if (no_swap)
					flags_q <= flags_in;
				else if (take_nmi)
					flags_q <= flags_nmi_q;
				else
					flags_q <= flags_irq_q;
			end else if (return_from_interrupt && mode_q != MIC_MODE_NORMAL) begin
				if (swapped_q) begin
					if (mode_q == MIC_MODE_NMI)
						flags_nmi_q <= flags_in;
					else
						flags_irq_q <= flags_in;
				end
				flags_q <= (mode_prev_q == MIC_MODE_IRQ) ? flags_irq_q : flags_norm_q;
				stack_valid_q <= 1'b0;
				mode_q <= mode_prev_q;
				mode_prev_q <= MIC_MODE_NORMAL;
				swapped_q <= 1'b1;
				inhibit_q <= mode_prev_q == MIC_MODE_IRQ;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	nmi_first_a: assert property (clk_en && any_take && take_nmi |=> grant_q.src == 3'h0)
		else $error("non-maskable not granted first");
	vector_map_a: assert property (grant_q.take && grant_q.src == 3'h1 |-> grant_q.vector == 12'hFF6)
		else $error("wrong vector for source one");
	no_nest_a: assert property (mode_q == MIC_MODE_IRQ |-> !(take1 || take2 || take3 || take4))
		else $error("maskable nested");
	prio_order_a: assert property (clk_en && any_take && take1 && !take_nmi |=> grant_q.src == 3'h1)
		else $error("source one lost priority");
	enable_block_a: assert property (!global_irq_enable |-> !(take1 || take2 || take3 || take4))
		else $error("maskable taken with enable clear");
	nowake_a: assert property (clk_en && !global_irq_enable |=> !wake_q)
		else $error("wake with enable clear");
	nmi_clear_a: assert property (clk_en && any_take && take_nmi && !nmi_fall |=> !nmi_latch_q)
		else $error("nmi latch not cleared");
	grant_pulse_a: assert property (grant_q.take |=> $past(instr_end) || !grant_q.take)
		else $error("grant without instruction end");
	push_pc_a: assert property (clk_en && any_take |=> stack0_q == $past(pc_in) && inhibit_q)
		else $error("pc not pushed on entry");
	opt_unused_a: assert property ((option_q & ~MIC_OPTION_USED) == 8'h00)
		else $error("unused option bits set");
	cov_nmi_c: cover property (grant_q.take && grant_q.src == 3'h0);
	cov_edge2_c: cover property (grant_q.take && grant_q.src == 3'h2);
	cov_noswap_c: cover property (grant_q.take && !grant_q.swap_flags);
	cov_return_c: cover property (return_from_interrupt && mode_q == MIC_MODE_IRQ);
	cov_prio1_c: cover property (grant_q.take && grant_q.src == 3'h1);

	// ---------------------------------------------------------------
	// Vector map and grant shape
	// ---------------------------------------------------------------
	vec0_map_a: assert property (grant_q.take && grant_q.src == 3'h0 |-> grant_q.vector == MIC_VEC0)
		else $error("wrong vector for source zero");

	vec2_map_a: assert property (grant_q.take && grant_q.src == 3'h2 |-> grant_q.vector == MIC_VEC2)
		else $error("wrong vector for source two");

	vec3_map_a: assert property (grant_q.take && grant_q.src == 3'h3 |-> grant_q.vector == MIC_VEC3)
		else $error("wrong vector for source three");

	vec4_map_a: assert property (grant_q.take && grant_q.src == 3'h4 |-> grant_q.vector == MIC_VEC4)
		else $error("wrong vector for source four");

	src_range_a: assert property (grant_q.take |-> grant_q.src <= 3'h4)
		else $error("grant names no source");

	take_end_a: assert property (!instr_end |-> !any_take)
		else $error("grant between instructions");

	// ---------------------------------------------------------------
	// Modes, flag sets and return
	// ---------------------------------------------------------------
	// Mode must leave normal on every entry, or a nested maskable could slip in
	enter_mode_a: assert property (clk_en && any_take |=> mode_q != MIC_MODE_NORMAL)
		else $error("entry left mode normal");

	nmi_mode_a: assert property (clk_en && any_take && take_nmi |=> mode_q == MIC_MODE_NMI)
		else $error("nmi entry without nmi mode");

	nmi_swap_a: assert property (clk_en && any_take && take_nmi |=> grant_q.swap_flags)
		else $error("nmi entry kept old flags");

	nmi_once_a: assert property (mode_q == MIC_MODE_NMI |-> !take_nmi)
		else $error("nmi nested in nmi");

	noswap_flags_a: assert property (clk_en && any_take && no_swap |=> flags_q == $past(flags_in))
		else $error("flags swapped during option clear");

	ret_mode_a: assert property (clk_en && !any_take && return_from_interrupt &&
		mode_q != MIC_MODE_NORMAL |=> mode_q == $past(mode_prev_q))
		else $error("return did not restore mode");

	ret_stack_a: assert property (clk_en && !any_take && return_from_interrupt &&
		mode_q != MIC_MODE_NORMAL |=> !stack_valid_q)
		else $error("return did not pop stack");

	// Leaving inhibit set after a return to normal would lock out all maskables
	ret_unmask_a: assert property (clk_en && !any_take && return_from_interrupt &&
		mode_q == MIC_MODE_IRQ && mode_prev_q == MIC_MODE_NORMAL |=> !inhibit_q)
		else $error("maskable lines left inhibited");

	// ---------------------------------------------------------------
	// Edge latches and levels
	// ---------------------------------------------------------------
	edge1_set_a: assert property (clk_en && !level_edge_select && s1_fall |=> edge1_q)
		else $error("source one edge lost");

	edge2_set_a: assert property (clk_en && s2_edge |=> edge2_q)
		else $error("source two edge lost");

	edge1_clr_a: assert property (clk_en && clr1 && !s1_fall |=> !edge1_q)
		else $error("source one latch kept");

	edge2_clr_a: assert property (clk_en && clr2 && !s2_edge |=> !edge2_q)
		else $error("source two latch kept");

	level1_a: assert property (level_edge_select |-> req1 == !src1_n)
		else $error("source one not level");

	spi_route_a: assert property (level_edge_select && ev_on[MIC_EV_SPI] |-> req1)
		else $error("serial event not on source one");

	art_route_a: assert property (ev_on[MIC_EV_ART] |-> !src3_n)
		else $error("reload timer not on source three");

	// ---------------------------------------------------------------
	// Register side
	// ---------------------------------------------------------------
	flag_set_a: assert property (clk_en && ev_rise[MIC_EV_TIMER] |=> evflag_q[MIC_EV_TIMER])
		else $error("timer flag not set");

	flag_clr_a: assert property (clk_en && flg_clr && pwdata[MIC_EV_TIMER] &&
		!ev_rise[MIC_EV_TIMER] |=> !evflag_q[MIC_EV_TIMER])
		else $error("timer flag not cleared");

	opt_write_a: assert property (clk_en && wr && pready && hit_opt |=>
		option_q == ($past(pwdata[7:0]) & MIC_OPTION_USED))
		else $error("option write lost");

	opt_rd_zero_a: assert property (clk_en && psel && !pwrite && hit_opt |=> prdata == 32'h0)
		else $error("option register readable");

	mask_write_a: assert property (clk_en && wr && pready && hit_msk |=>
		evmask_q == $past(pwdata[MIC_NEV-1:0]))
		else $error("event mask write lost");

	pready_pulse_a: assert property (clk_en && pready |=> !pready)
		else $error("ready held too long");

	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");

	awake_only_a: assert property (clk_en && !low_power |=> !wake_q)
		else $error("wake while running");
endmodule // mic_irq_ctrl

//--- mic_pkg.sv
package mic_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] MIC_OPTION_OFF = 8'hC8;
	localparam logic [7:0] MIC_EVMASK_OFF = 8'hCC;
	localparam logic [7:0] MIC_EVFLAG_OFF = 8'hD0;
	localparam logic [7:0] MIC_STATUS_OFF = 8'hD4;
	localparam logic [7:0] MIC_OPTION_RST = 8'h00;
	localparam int MIC_LVL_SEL_BIT = 6;
	localparam int MIC_POL_SEL_BIT = 5;
	localparam int MIC_GLB_EN_BIT = 4;
	localparam logic [7:0] MIC_OPTION_USED = 8'h70;
	localparam int MIC_NEV = 10;
	localparam logic [MIC_NEV-1:0] MIC_EVMASK_RST = 10'h000;
	// ---------------------------------------------------------------
	// Event positions in the mask and flag registers
	// ---------------------------------------------------------------
	localparam int MIC_EV_TIMER = 0;
	localparam int MIC_EV_CONV = 1;
	localparam int MIC_EV_SRX = 2;
	localparam int MIC_EV_STX = 3;
	localparam int MIC_EV_ART = 4;
	localparam int MIC_EV_SPI = 5;
	localparam int MIC_EV_PA = 6;
	localparam int MIC_EV_PE = 7;
	localparam int MIC_EV_PB = 8;
	localparam int MIC_EV_PD = 9;
	// ---------------------------------------------------------------
	// Vectors
	// ---------------------------------------------------------------
	localparam logic [11:0] MIC_VEC0 = 12'hFFC;
	localparam logic [11:0] MIC_VEC1 = 12'hFF6;
	localparam logic [11:0] MIC_VEC2 = 12'hFF4;
	localparam logic [11:0] MIC_VEC3 = 12'hFF2;
	localparam logic [11:0] MIC_VEC4 = 12'hFF0;
	localparam int MIC_LDI_MISS_CYC = 3;

	typedef enum logic [1:0] {
		MIC_MODE_NORMAL = 2'b00,
		MIC_MODE_IRQ = 2'b01,
		MIC_MODE_NMI = 2'b11
	} mic_mode_e;

	typedef struct packed {
		logic carry;
		logic zero;
	} mic_flags_s;

	typedef struct packed {
		logic take;
		logic [2:0] src;
		logic [11:0] vector;
		logic swap_flags;
	} mic_grant_s;
endpackage

//--- mic_core_model.sv
`timescale 1ns/100ps
module mic_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic step,
	input wire logic ret,
	input wire mic_pkg::mic_grant_s grant_q,
	output logic instr_end,
	output logic return_from_interrupt,
	output logic [11:0] pc_in,
	output mic_pkg::mic_flags_s flags_in
);
	import mic_pkg::*;
	// ---------------------------------------------------------------
	// Core sequencer: one sample point per finished instruction
	// ---------------------------------------------------------------
	logic [11:0] pc_q;
	assign instr_end = step;
	assign return_from_interrupt = ret;
	assign pc_in = pc_q;
	// Live flags follow the PC so a stale flag set shows up as a mismatch
	assign flags_in = mic_flags_s'(pc_q[1:0]);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= 12'h100;
		end else if (grant_q.take) begin
			pc_q <= grant_q.vector;
		end else if (instr_end) begin
			pc_q <= pc_q + 12'h001;
		end
	end
endmodule // mic_core_model

//--- tb.sv
`timescale 1ns/100ps
module tb;
	import mic_pkg::*;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic nmi_pin_n = 1'b1;
	logic step = 1'b0;
	logic ret = 1'b0;
	logic ldi = 1'b0;
	logic sleep = 1'b0;
	logic [MIC_NEV-1:0] event_in = '0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, instr_end, return_from_interrupt, wake_q, er;
	logic [11:0] pc_in, stack0_q;
	mic_flags_s flags_in, flags_q;
	mic_grant_s grant_q;
	mic_mode_e mode_q;
	int errors = 0;
	int checks_done = 0;
	always #10 pclk = ~pclk;
	mic_irq_ctrl u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nmi_pin_n(nmi_pin_n), .event_in(event_in),
		.instr_end(instr_end), .ldi_opt_clr(ldi),
		.return_from_interrupt(return_from_interrupt), .low_power(sleep),
		.pc_in(pc_in), .flags_in(flags_in), .grant_q(grant_q), .stack0_q(stack0_q),
		.flags_q(flags_q), .mode_q(mode_q), .wake_q(wake_q));
	mic_core_model u_core (.pclk(pclk), .presetn(presetn), .step(step), .ret(ret),
		.grant_q(grant_q), .instr_end(instr_end),
		.return_from_interrupt(return_from_interrupt), .pc_in(pc_in),
		.flags_in(flags_in));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Ends on a rising edge so the caller may drive by non-blocking assignment
	task automatic step_chk(input logic tk, input logic [2:0] s, input logic [11:0] v,
		input logic sw);
		logic [11:0] pc;
		@(posedge pclk);
		step <= 1'b1;
		#1;
		pc = pc_in;
		@(posedge pclk);
		step <= 1'b0;
		#1;
		chk("take", grant_q.take, tk);
		if (tk) begin
			chk("src", grant_q.src, s);
			chk("vector", grant_q.vector, v);
			chk("stack", stack0_q, pc);
			chk("swap", grant_q.swap_flags, sw);
		end
		@(posedge pclk);
	endtask
	task automatic ret_pulse();
		@(posedge pclk);
		ret <= 1'b1;
		@(posedge pclk);
		ret <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// Sync plus edge stage needs three edges before a request is visible
	task automatic drive(input logic [MIC_NEV-1:0] ev, input logic lp);
		@(posedge pclk);
		event_in <= ev;
		sleep <= lp;
		repeat (4) @(posedge pclk);
	endtask
	task automatic nmi_pulse();
		@(posedge pclk);
		nmi_pin_n <= 1'b0;
		repeat (3) @(posedge pclk);
		nmi_pin_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, MIC_OPTION_OFF, 32'h0);
		chk("option_rst", rd, 32'h0);
		apb(1'b1, MIC_OPTION_OFF, 32'hFF);
		apb(1'b0, MIC_OPTION_OFF, 32'h0);
		chk("option_wo", rd, 32'h0);
		apb(1'b0, MIC_EVMASK_OFF, 32'h0);
		chk("evmask_rst", rd, {22'h0, MIC_EVMASK_RST});
		apb(1'b0, 8'hF0, 32'h0);
		chk("unmapped_err", er, 32'h1);
		apb(1'b1, MIC_EVMASK_OFF, 32'h3FF);
		apb(1'b0, MIC_EVMASK_OFF, 32'h0);
		chk("evmask_rw", rd, 32'h3FF);
	endtask
	task automatic t_nmi_gen_off();
		apb(1'b1, MIC_OPTION_OFF, 32'h0);
		drive(10'h001, 1'b1);
		nmi_pulse();
		chk("wake", wake_q, 32'h0);
		step_chk(1'b1, 3'd0, MIC_VEC0, 1'b1);
		chk("mode_nmi", mode_q, MIC_MODE_NMI);
		ret_pulse();
		chk("mode_back", mode_q, MIC_MODE_NORMAL);
		chk("flags_back", flags_q, stack0_q[1:0]);
		step_chk(1'b0, 3'd0, 12'h0, 1'b0);
		apb(1'b0, MIC_EVFLAG_OFF, 32'h0);
		chk("timer_flag", rd[MIC_EV_TIMER], 32'h1);
		drive(10'h000, 1'b0);
	endtask
	task automatic t_priority();
		logic [11:0] vt [4];
		logic [MIC_NEV-1:0] bt [4];
		vt = '{MIC_VEC1, MIC_VEC2, MIC_VEC3, MIC_VEC4};
		bt = '{10'h020, 10'h100, 10'h010, 10'h001};
		apb(1'b1, MIC_OPTION_OFF, 32'h10);
		drive(10'h131, 1'b0);
		for (int i = 0; i < 4; i++) begin
			step_chk(1'b1, 3'(i + 1), vt[i], 1'b1);
			chk("mode_irq", mode_q, MIC_MODE_IRQ);
			if (i == 0) begin
				chk("flags_irq", flags_q, 32'h0);
				step_chk(1'b0, 3'd0, 12'h0, 1'b0);
				nmi_pulse();
				step_chk(1'b1, 3'd0, MIC_VEC0, 1'b1);
				ret_pulse();
				chk("mode_nest", mode_q, MIC_MODE_IRQ);
				step_chk(1'b0, 3'd0, 12'h0, 1'b0);
			end
			drive(event_in & ~bt[i], 1'b0);
			ret_pulse();
			chk("mode_ret", mode_q, MIC_MODE_NORMAL);
		end
		step_chk(1'b0, 3'd0, 12'h0, 1'b0);
	endtask
	task automatic t_edges_ldi();
		apb(1'b1, MIC_OPTION_OFF, 32'h30);
		drive(10'h100, 1'b0);
		step_chk(1'b0, 3'd0, 12'h0, 1'b0);
		drive(10'h000, 1'b0);
		step_chk(1'b1, 3'd2, MIC_VEC2, 1'b1);
		ret_pulse();
		drive(10'h001, 1'b1);
		chk("wake_on", wake_q, 32'h1);
		ldi <= 1'b1;
		step_chk(1'b1, 3'd4, MIC_VEC4, 1'b0);
		chk("flags_noswap", flags_q, stack0_q[1:0]);
		ldi <= 1'b0;
		drive(10'h000, 1'b0);
		ret_pulse();
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_nmi_gen_off();
		t_priority();
		t_edges_ldi();
		give_verdict();
	end
endmodule // tb
